// ===== rtl/prox_link_if.sv
// byte-level link between the sensor host and the sensor register file
`timescale 1ns/1ps
interface prox_link_if;
  logic       frameStart;
  logic       wrStrobe;
  logic [7:0] wrByte;
  logic       rdStrobe;
  logic       rdAck;
  logic [7:0] rdByte;

  modport host (
    output frameStart,
    output wrStrobe,
    output wrByte,
    output rdStrobe,
    input  rdAck,
    input  rdByte
  );

  modport device (
    input  frameStart,
    input  wrStrobe,
    input  wrByte,
    input  rdStrobe,
    output rdAck,
    output rdByte
  );
endinterface

// ===== rtl/prox_pkg.sv
// constants shared by both ends of the proximity sensor register link
//==========================================================
package prox_pkg;

  //==========================================================
  // device register offsets
  localparam logic [4:0] REG_ENABLE          = 5'h00;
  localparam logic [4:0] REG_AMBIENT_TIME    = 5'h01;
  localparam logic [4:0] REG_PROX_TIME       = 5'h02;
  localparam logic [4:0] REG_IDLE_INTERVAL   = 5'h03;
  localparam logic [4:0] REG_LOWER_THRESH_LO = 5'h08;
  localparam logic [4:0] REG_LOWER_THRESH_HI = 5'h09;
  localparam logic [4:0] REG_UPPER_THRESH_LO = 5'h0A;
  localparam logic [4:0] REG_UPPER_THRESH_HI = 5'h0B;
  localparam logic [4:0] REG_EVENT_FILTER    = 5'h0C;
  localparam logic [4:0] REG_MISC_SETTINGS   = 5'h0D;
  localparam logic [4:0] REG_LED_BURST       = 5'h0E;
  localparam logic [4:0] REG_ANALOG_DRIVE    = 5'h0F;
  localparam logic [4:0] REG_PART_ID         = 5'h12;
  localparam logic [4:0] REG_DEVICE_FLAGS    = 5'h13;
  localparam logic [4:0] REG_RESULT_LO       = 5'h18;
  localparam logic [4:0] REG_RESULT_HI       = 5'h19;

  //==========================================================
  // reset values
  localparam logic [7:0] RST_ZERO          = 8'h00;
  localparam logic [7:0] RST_PROX_TIME     = 8'hFF;
  localparam logic [7:0] RST_IDLE_INTERVAL = 8'hFF;
  localparam logic [7:0] AMBIENT_TIME_INIT = 8'hFF;

  //==========================================================
  // command byte layout
  localparam int         CMD_FLAG_BIT   = 7;
  localparam int         CMD_TYPE_HI    = 6;
  localparam int         CMD_TYPE_LO    = 5;
  localparam int         CMD_ADDR_HI    = 4;
  localparam logic [1:0] TYPE_REPEAT    = 2'h0;
  localparam logic [1:0] TYPE_AUTOINC   = 2'h1;
  localparam logic [1:0] TYPE_RESERVED  = 2'h2;
  localparam logic [1:0] TYPE_SPECIAL   = 2'h3;
  localparam logic [4:0] FUNC_INT_CLEAR = 5'h05;
  localparam int         FLAG_PROX_INT  = 5;

  //==========================================================
  // host controller registers and fields
  localparam logic [3:0] HOST_REQUEST = 4'h0;
  localparam logic [3:0] HOST_STATE   = 4'h4;
  localparam logic [3:0] HOST_EVENTS  = 4'h8;
  localparam logic [3:0] HOST_MASK    = 4'hC;
  localparam int         REQ_READ_BIT  = 8;
  localparam int         REQ_FRAME_BIT = 9;
  localparam int         EV_DONE       = 0;
  localparam int         EV_REFUSED    = 1;
  localparam int         EV_WIDTH      = 2;

  typedef enum logic [0:0] {HOST_IDLE, HOST_WAIT_READ} host_state_e;

endpackage

// ===== rtl/prox_sensor_host.sv
// host-side controller: Wishbone slave that issues link byte transfers
`timescale 1ns/1ps
module prox_sensor_host
  import prox_pkg::*;
#(
  parameter int AW = 4
)(
  input  wire logic          clk,
  input  wire logic          resetn,
  prox_link_if.host          link,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [AW-1:0] wb_adr_i,
  input  wire logic [31:0]   wb_dat_i,
  input  wire logic [3:0]    wb_sel_i,
  output logic [31:0]        wb_dat_o,
  output logic               wb_ack_o,
  output logic               irq
);

  //==========================================================
  // elaboration check: the decoder needs four address bits
  if (AW < 4)
  begin
    $error("address width must be at least 4");
  end

  host_state_e          state;
  logic [EV_WIDTH-1:0]  events;
  logic [EV_WIDTH-1:0]  mask;
  logic [7:0]           lastRead;
  logic                 wrDone;
  logic                 access;
  logic [3:0]           offset;
  logic                 reqWrite;
  logic                 busy;
  logic                 accept;

  //==========================================================
  // decode; an access is taken in the cycle before ack rises
  assign access   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign offset   = wb_adr_i[3:0];
  assign reqWrite = access & wb_we_i & (offset == HOST_REQUEST) & (&wb_sel_i[1:0]);
  assign busy     = (state != HOST_IDLE) | link.wrStrobe | link.rdStrobe;
  // a request while the link is busy is refused, not queued
  assign accept   = reqWrite & ~busy;

  //==========================================================
  // link sequencer; strobes last one cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state           <= HOST_IDLE;
      link.frameStart <= 1'b0;
      link.wrStrobe   <= 1'b0;
      link.wrByte     <= 8'h00;
      link.rdStrobe   <= 1'b0;
      lastRead        <= 8'h00;
    end
    else
    begin
      link.frameStart <= 1'b0;
      link.wrStrobe   <= 1'b0;
      link.rdStrobe   <= 1'b0;
      case (state)
        HOST_IDLE:
        begin
          if (accept)
          begin
            link.frameStart <= wb_dat_i[REQ_FRAME_BIT];
            link.wrByte     <= wb_dat_i[7:0];  // type 10 is software's to avoid
            if (wb_dat_i[REQ_READ_BIT])
            begin
              link.rdStrobe <= 1'b1;
              state         <= HOST_WAIT_READ;
            end
            else
            begin
              link.wrStrobe <= 1'b1;
            end
          end
        end
        HOST_WAIT_READ:
        begin
          if (link.rdAck)
          begin
            lastRead <= link.rdByte;
            state    <= HOST_IDLE;
          end
        end
        default:
        begin
          state <= HOST_IDLE;
        end
      endcase
    end
  end

  // marks the cycle after a byte write went out
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrDone <= 1'b0;
    end
    else
    begin
      wrDone <= link.wrStrobe;
    end
  end

  //==========================================================
  // sticky events, read clears, a new event wins over the clear
  logic [EV_WIDTH-1:0] setBits;
  logic                readEvents;

  assign setBits[EV_DONE]    = wrDone | ((state == HOST_WAIT_READ) & link.rdAck);
  assign setBits[EV_REFUSED] = reqWrite & busy;
  assign readEvents          = access & ~wb_we_i & (offset == HOST_EVENTS);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      events <= '0;
    end
    else
    begin
      events <= (readEvents ? '0 : events) | setBits;
    end
  end

  // mask and level interrupt
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mask <= '0;
      irq  <= 1'b0;
    end
    else
    begin
      if (access && wb_we_i && offset == HOST_MASK && wb_sel_i[0])
      begin
        mask <= wb_dat_i[EV_WIDTH-1:0];
      end
      irq <= |(events & mask);  // one cycle behind the status bits
    end
  end

  //==========================================================
  // bus answer: ack one cycle after the request, then dropped
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= access;
      wb_dat_o <= 32'h0000_0000;
      if (access && !wb_we_i)
      begin
        case (offset)
          HOST_STATE:  wb_dat_o <= {16'h0000, lastRead, 7'h00, busy};
          HOST_EVENTS: wb_dat_o <= {{(32-EV_WIDTH){1'b0}}, events};
          HOST_MASK:   wb_dat_o <= {{(32-EV_WIDTH){1'b0}}, mask};
          default:     wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// ===== rtl/prox_sensor_register_file.sv
// sensor-side register file with command byte decoder
//
// The byte link device port is this design's own decision.
`timescale 1ns/1ps
module prox_sensor_register_file
  import prox_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'h5A  // arbitrary identification value
)(
  input  wire logic        clk,
  input  wire logic        resetn,
  prox_link_if.device      link,
  input  wire logic        resultLoad,
  input  wire logic [15:0] resultIn,
  input  wire logic [7:0]  statusIn,
  input  wire logic        proxIntSet,
  output logic [7:0]       enable,
  output logic [7:0]       ambientConversionTime,
  output logic [7:0]       proximityConversionTime,
  output logic [7:0]       idleInterval,
  output logic [15:0]      lowerThreshold,
  output logic [15:0]      upperThreshold,
  output logic [7:0]       eventFilterCount,
  output logic [7:0]       miscSettings,
  output logic [7:0]       ledBurstLength,
  output logic [7:0]       analogDriveSettings,
  output logic             proxIntPending,
  output logic             proxIntClear
);

  //==========================================================
  // elaboration check: a zero identifier would read like an empty slot
  if (PART_ID == 8'h00)
  begin
    $error("part identifier must be non-zero");
  end

  //==========================================================
  // storage
  logic [7:0] cfg [16];       // offsets 0x00..0x0F, holes never written
  logic [7:0] deviceFlags;
  logic [7:0] resultLo;
  logic [7:0] resultHi;
  logic [4:0] regAddr;
  logic       autoInc;
  logic       rdAckQ;
  logic [7:0] rdByteQ;

  // reset value of each configuration slot
  function automatic logic [7:0] cfgReset(input logic [4:0] a);
    case (a)
      REG_PROX_TIME:     cfgReset = RST_PROX_TIME;
      REG_IDLE_INTERVAL: cfgReset = RST_IDLE_INTERVAL;
      default:           cfgReset = RST_ZERO;
    endcase
  endfunction

  // true for offsets software may write
  function automatic logic isWritable(input logic [4:0] a);
    case (a)
      REG_ENABLE, REG_AMBIENT_TIME, REG_PROX_TIME, REG_IDLE_INTERVAL,
      REG_LOWER_THRESH_LO, REG_LOWER_THRESH_HI,
      REG_UPPER_THRESH_LO, REG_UPPER_THRESH_HI,
      REG_EVENT_FILTER, REG_MISC_SETTINGS, REG_LED_BURST, REG_ANALOG_DRIVE:
        isWritable = 1'b1;
      default:
        isWritable = 1'b0;  // read-only and unmapped
    endcase
  endfunction

  //==========================================================
  // byte classification
  logic       isCommand;
  logic       isData;
  logic [1:0] cmdType;
  logic [4:0] cmdAddr;
  logic       latchAddr;
  logic       clearRequest;
  logic       stepAddr;

  // only the first byte of a frame can be a command
  assign isCommand    = link.wrStrobe & link.frameStart & link.wrByte[CMD_FLAG_BIT];
  assign isData       = link.wrStrobe & ~isCommand;
  assign cmdType      = link.wrByte[CMD_TYPE_HI:CMD_TYPE_LO];
  assign cmdAddr      = link.wrByte[CMD_ADDR_HI:0];
  // reserved type is dropped whole so a stray one cannot move the pointer
  assign latchAddr    = isCommand & (cmdType == TYPE_REPEAT || cmdType == TYPE_AUTOINC);
  assign clearRequest = isCommand & (cmdType == TYPE_SPECIAL)
                        & (cmdAddr == FUNC_INT_CLEAR);
  assign stepAddr     = (isData | link.rdStrobe) & autoInc;

  //==========================================================
  // register pointer and transfer mode
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      regAddr <= 5'h00;
      autoInc <= 1'b0;
    end
    else if (latchAddr)
    begin
      regAddr <= cmdAddr;
      autoInc <= (cmdType == TYPE_AUTOINC);
    end
    else if (stepAddr)
    begin
      regAddr <= regAddr + 5'h01;  // wraps at 0x1F
    end
  end

  //==========================================================
  // configuration writes, always at the held pointer
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 16; i++)
      begin
        cfg[i] <= cfgReset(5'(i));
      end
    end
    else if (isData && isWritable(regAddr))
    begin
      cfg[regAddr[3:0]] <= link.wrByte;
    end
  end

  //==========================================================
  // results, loaded only by the measurement core
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      resultLo <= RST_ZERO;
      resultHi <= RST_ZERO;
    end
    else if (resultLoad)
    begin
      resultLo <= resultIn[7:0];
      resultHi <= resultIn[15:8];
    end
  end

  //==========================================================
  // flags: interrupt bit is sticky, a new event beats the clear
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      deviceFlags <= RST_ZERO;
    end
    else
    begin
      deviceFlags <= statusIn;
      deviceFlags[FLAG_PROX_INT] <= proxIntSet
                                    | (deviceFlags[FLAG_PROX_INT] & ~clearRequest);
    end
  end

  // one-cycle clear pulse, no second write needed
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      proxIntClear <= 1'b0;
    end
    else
    begin
      proxIntClear <= clearRequest;
    end
  end

  //==========================================================
  // read answer, one cycle after the strobe
  logic [7:0] readValue;

  always_comb
  begin
    readValue = 8'h00;  // unmapped reads as zero
    case (regAddr)
      REG_PART_ID:      readValue = PART_ID;
      REG_DEVICE_FLAGS: readValue = deviceFlags;
      REG_RESULT_LO:    readValue = resultLo;
      REG_RESULT_HI:    readValue = resultHi;
      default:
      begin
        if (isWritable(regAddr))
        begin
          readValue = cfg[regAddr[3:0]];
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdAckQ  <= 1'b0;
      rdByteQ <= 8'h00;
    end
    else
    begin
      rdAckQ <= link.rdStrobe;
      if (link.rdStrobe)
      begin
        rdByteQ <= readValue;  // kept pointer, no command needed
      end
    end
  end

  //==========================================================
  // outputs straight from storage
  assign link.rdAck              = rdAckQ;
  assign link.rdByte             = rdByteQ;
  assign enable                  = cfg[REG_ENABLE[3:0]];
  assign ambientConversionTime   = cfg[REG_AMBIENT_TIME[3:0]];
  assign proximityConversionTime = cfg[REG_PROX_TIME[3:0]];
  assign idleInterval            = cfg[REG_IDLE_INTERVAL[3:0]];
  assign lowerThreshold          = {cfg[REG_LOWER_THRESH_HI[3:0]], cfg[REG_LOWER_THRESH_LO[3:0]]};
  assign upperThreshold          = {cfg[REG_UPPER_THRESH_HI[3:0]], cfg[REG_UPPER_THRESH_LO[3:0]]};
  assign eventFilterCount        = cfg[REG_EVENT_FILTER[3:0]];
  assign miscSettings            = cfg[REG_MISC_SETTINGS[3:0]];
  assign ledBurstLength          = cfg[REG_LED_BURST[3:0]];
  assign analogDriveSettings     = cfg[REG_ANALOG_DRIVE[3:0]];
  assign proxIntPending          = deviceFlags[FLAG_PROX_INT];

endmodule

// ===== tb/prox_link_assertions.sv
// concurrent checks on the byte link between host controller and register file
`timescale 1ns/1ps
module prox_link_assertions
  import prox_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       frameStart,
  input wire logic       wrStrobe,
  input wire logic [7:0] wrByte,
  input wire logic       rdStrobe,
  input wire logic       rdAck,
  input wire logic [7:0] rdByte
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  //==========================================================
  // read answer timing
  property p_ack_next;
    rdStrobe |=> (rdAck && !rdStrobe) ##1 !rdAck;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("read answer not one cycle");
  property p_ack_cause;
    rdAck |-> $past(rdStrobe);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer without read");
  // read data moves only with its answer, so a slow host still sees it
  property p_rd_hold;
    $changed(rdByte) |-> rdAck;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read byte moved");

  //==========================================================
  // host request shape
  property p_wr_hold;
    !(wrStrobe || rdStrobe) |-> $stable(wrByte);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write byte moved");
  property p_wr_pulse;
    wrStrobe |=> !wrStrobe && !rdStrobe;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  property p_excl;
    !(wrStrobe && rdStrobe);
  endproperty
  a_excl: assert property (p_excl) else $error("both strobes high");
  property p_frame;
    frameStart |-> wrStrobe || rdStrobe;
  endproperty
  a_frame: assert property (p_frame) else $error("frame start alone");
  property p_reserved;
    frameStart && wrStrobe && wrByte[CMD_FLAG_BIT] |-> wrByte[6:5] != TYPE_RESERVED;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved command type");

  //==========================================================
  // main scenarios reached
  c_autoinc: cover property (frameStart && wrStrobe && wrByte[6:5] == TYPE_AUTOINC);
  c_clear: cover property (frameStart && wrStrobe && wrByte == 8'hE5);
  c_read: cover property (rdStrobe ##1 rdAck);
endmodule

// ===== tb/tb_prox_sensor_register_file.sv
// bench joining host controller and register file, driven over Wishbone
`timescale 1ns/1ps
module tb_prox_sensor_register_file
  import prox_pkg::*;
;
  localparam logic [7:0] ID_VAL = 8'hC3; // arbitrary identification value
  logic        clk, resetn, cyc, stb, we, ack, irq, resultLoad, proxIntSet;
  logic        proxIntPending, proxIntClear;
  logic [3:0]  adr;
  logic [31:0] datW, datR;
  logic [15:0] resultIn, lowerThreshold, upperThreshold;
  logic [7:0]  statusIn, enable, ambientTime, proxTime, idleInterval;
  logic [7:0]  filterCount, miscSettings, ledBurst, analogDrive;
  int          err_total, n_tests, clrCount;

  //==========================================================
  // structure
  prox_link_if i_prox_link_if ();
  prox_sensor_host #(.AW(4)) i_prox_sensor_host (.clk(clk), .resetn(resetn),
    .link(i_prox_link_if), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(datW), .wb_sel_i(4'hF), .wb_dat_o(datR), .wb_ack_o(ack), .irq(irq));
  prox_sensor_register_file #(.PART_ID(ID_VAL)) i_prox_sensor_register_file (.clk(clk),
    .resetn(resetn), .link(i_prox_link_if), .resultLoad(resultLoad), .resultIn(resultIn),
    .statusIn(statusIn), .proxIntSet(proxIntSet), .enable(enable),
    .ambientConversionTime(ambientTime), .proximityConversionTime(proxTime),
    .idleInterval(idleInterval), .lowerThreshold(lowerThreshold),
    .upperThreshold(upperThreshold), .eventFilterCount(filterCount),
    .miscSettings(miscSettings), .ledBurstLength(ledBurst),
    .analogDriveSettings(analogDrive), .proxIntPending(proxIntPending),
    .proxIntClear(proxIntClear));
  prox_link_assertions i_prox_link_assertions (.clk(clk), .resetn(resetn),
    .frameStart(i_prox_link_if.frameStart), .wrStrobe(i_prox_link_if.wrStrobe),
    .wrByte(i_prox_link_if.wrByte), .rdStrobe(i_prox_link_if.rdStrobe),
    .rdAck(i_prox_link_if.rdAck), .rdByte(i_prox_link_if.rdByte));

  //==========================================================
  // clock, clear-pulse counter, watchdog
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
    if (proxIntClear === 1'b1) clrCount++;
  // whole run needs a few hundred cycles; this leaves a wide margin
  initial
  begin
    #500000;
    err_total++;
    print_verdict();
  end

  //==========================================================
  // shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle: request held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datW <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    check(ack, 1'b1);
    q = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // link request, then poll events until done
  task automatic req(input logic [9:0] r);
    logic [31:0] q;
    int n;
    wb(1'b1, HOST_REQUEST, {22'h0, r}, q);
    n = 0;
    do
    begin
      wb(1'b0, HOST_EVENTS, 32'h0, q);
      n++;
    end
    while (q[EV_DONE] !== 1'b1 && n < 20);
    check(q[EV_WIDTH-1:0], 2'h1);
  endtask
  task automatic cmd(input logic [7:0] b);
    req({2'h2, b});
  endtask
  task automatic put(input logic [7:0] b);
    req({2'h0, b});
  endtask
  task automatic get(input logic fs, input logic [7:0] exp);
    logic [31:0] q;
    req({fs, 1'b1, 8'h00});
    wb(1'b0, HOST_STATE, 32'h0, q);
    check({q[15:8], q[0]}, {exp, 1'b0});
  endtask

  //==========================================================
  // scenarios
  task automatic t_reset;
    check({enable, ambientTime, proxTime, idleInterval}, 32'h0000FFFF);
    check({lowerThreshold, upperThreshold}, 32'h0);
    check(proxIntPending, 1'b0);
    check({filterCount, miscSettings, ledBurst, analogDrive}, 32'h0);
    cmd(8'h81);
    put(8'hFF);
    check(ambientTime, 8'hFF);
    cmd(8'h92);
    put(8'h00);
    get(1'b0, ID_VAL);
    $display("test reset done");
  endtask
  task automatic t_autoinc;
    cmd(8'hA8);
    for (int i = 1; i <= 4; i++) put(8'(8'h11 * i));
    check({upperThreshold, lowerThreshold}, 32'h44332211);
    cmd(8'hA8);
    for (int i = 1; i <= 4; i++) get(1'b0, 8'(8'h11 * i));
    cmd(8'hBF);
    put(8'h3C);
    put(8'h07);
    check(enable, 8'h07);
    $display("test autoinc done");
  endtask
  task automatic t_repeat;
    cmd(8'h8E);
    put(8'h05);
    put(8'h06);
    check({ledBurst, analogDrive}, 16'h0600);
    get(1'b1, 8'h06);
    get(1'b1, 8'h06);
    $display("test repeat done");
  endtask
  task automatic t_readonly;
    @(posedge clk);
    resultLoad <= 1'b1;
    resultIn <= 16'hBEEF;
    statusIn <= 8'h03;
    @(posedge clk);
    resultLoad <= 1'b0;
    cmd(8'hB8);
    put(8'h01);
    put(8'h02);
    cmd(8'hB8);
    get(1'b0, 8'hEF);
    get(1'b0, 8'hBE);
    get(1'b0, 8'h00);
    cmd(8'h93);
    get(1'b0, 8'h03);
    $display("test readonly done");
  endtask
  task automatic t_intclr;
    int c0;
    cmd(8'h8C);
    @(posedge clk);
    proxIntSet <= 1'b1;
    @(posedge clk);
    proxIntSet <= 1'b0;
    repeat (2) @(posedge clk);
    check(proxIntPending, 1'b1);
    c0 = clrCount;
    cmd(8'hE6);
    check(proxIntPending, 1'b1);
    cmd(8'hE5);
    check(proxIntPending, 1'b0);
    check(32'(clrCount - c0), 32'h1);
    put(8'h0A);
    check(filterCount, 8'h0A);
    $display("test intclr done");
  endtask
  task automatic t_irq;
    logic [31:0] q;
    int n;
    wb(1'b1, HOST_MASK, 32'h1, q);
    wb(1'b0, HOST_MASK, 32'h0, q);
    check(q[1:0], 2'h1);
    wb(1'b1, HOST_REQUEST, 32'h0000000B, q);
    n = 0;
    while (irq !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    check(irq, 1'b1);
    wb(1'b0, HOST_EVENTS, 32'h0, q);
    check(q[1:0], 2'h1);
    repeat (2) @(posedge clk);
    check({irq, filterCount}, 9'h00B);
    wb(1'b1, HOST_MASK, 32'h0, q);
    put(8'h0C);
    check(irq, 1'b0);
    wb(1'b0, 4'h2, 32'h0, q);
    check(q, 32'h0);
    $display("test irq done");
  endtask

  //==========================================================
  // verdict and main sequence
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    {resetn, cyc, stb, we, resultLoad, proxIntSet} = 6'h0;
    {adr, datW, resultIn, statusIn} = 60'h0;
    {err_total, n_tests, clrCount} = 96'h0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_autoinc();
    t_repeat();
    t_readonly();
    t_intclr();
    t_irq();
    print_verdict();
  end
endmodule
